/* hw/ptc_regs.sv */
// PLL bias, lane pre-emphasis, aux output and PLL pin override registers
`timescale 1ns/100ps
`include "ptc_consts.svh"

module ptc_regs (
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    input  wire logic       ser_ui_strobe,
    input  wire logic       ser_reinit,
    input  wire logic       timestamp_input,
    input  wire logic       pll_enable_pin,
    input  wire logic       single_ended_ref_pin,
    input  wire logic       clock_config_pin_0,
    input  wire logic       clock_config_pin_1,
    output logic      [6:0] oscillator_bias_level,
    output logic      [3:0] lane_preemphasis,
    output logic            aux_output_pins,
    output logic            pll_enable,
    output logic            single_ended_ref_sel,
    output logic      [1:0] ref_out_c_divide,
    output logic      [1:0] ref_out_d_divide
);
    logic [7:0] bias_q;
    logic [7:0] preemph_q;
    logic [7:0] aux_q;
    logic [7:0] ovr_q;
    logic [7:0] rdata_q;
    logic       aux_out_q;
    logic [4:0] ui_cnt_q;
    logic       pll_en_q;
    logic       se_sel_q;
    logic [1:0] ref_c_q;
    logic [1:0] ref_d_q;

    // Address decode and read selection
    wire        wr_bias    = reg_wr && (reg_addr == `PTC_OFS_BIAS);
    wire        wr_preemph = reg_wr && (reg_addr == `PTC_OFS_PREEMPH);
    wire        wr_aux     = reg_wr && (reg_addr == `PTC_OFS_AUX);
    wire        wr_ovr     = reg_wr && (reg_addr == `PTC_OFS_OVR);
    wire [7:0]  rd_mux =
        (reg_addr == `PTC_OFS_BIAS)    ? bias_q    :
        (reg_addr == `PTC_OFS_PREEMPH) ? preemph_q :
        (reg_addr == `PTC_OFS_AUX)     ? aux_q     :
        (reg_addr == `PTC_OFS_OVR)     ? ovr_q     : `PTC_RD_UNMAPPED;

    // Reserved bits are stored as written; software keeps them at reset value
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            bias_q    <= `PTC_RST_BIAS;
            preemph_q <= `PTC_RST_PREEMPH;
            aux_q     <= `PTC_RST_AUX;
            ovr_q     <= `PTC_RST_OVR;
            rdata_q   <= `PTC_RD_UNMAPPED;
        end
        else
        begin
            if (wr_bias)
                bias_q <= reg_wdata;
            if (wr_preemph)
                preemph_q <= reg_wdata;
            if (wr_aux)
                aux_q <= reg_wdata;
            if (wr_ovr)
                ovr_q <= reg_wdata;
            if (reg_rd)
                rdata_q <= rd_mux;
        end
    end

    // Auxiliary output generation
    wire             aux_en  = aux_q[`PTC_AUX_EN_BIT];
    wire [2:0]       aux_sel = aux_q[`PTC_AUX_SEL_MSB:0];
    wire             ser_mode = aux_en && (aux_sel <= 3'(ptc_pkg::PTC_AUX_UI64));
    wire             stamp_mode = aux_en &&
                                  (aux_sel == 3'(ptc_pkg::PTC_AUX_STAMP));
    wire [4:0]       half_ui =
        (aux_sel == 3'(ptc_pkg::PTC_AUX_UI16)) ? `PTC_HALF_16UI :
        (aux_sel == 3'(ptc_pkg::PTC_AUX_UI32)) ? `PTC_HALF_32UI :
                                                 `PTC_HALF_64UI;
    wire             half_done = ser_ui_strobe &&
                                 (ui_cnt_q == half_ui - 5'h01);
    // A serializer restart parks the divided clock low and restarts its phase
    wire             ser_hold  = !ser_mode || ser_reinit;
    wire [4:0]       ui_cnt_d  = ser_hold      ? 5'h00 :
                                 half_done     ? 5'h00 :
                                 ser_ui_strobe ? ui_cnt_q + 5'h01 :
                                                 ui_cnt_q;
    // Reserved selects and a cleared enable both leave the pins low
    wire             aux_out_d = stamp_mode ? timestamp_input :
                                 ser_hold   ? 1'b0 :
                                 half_done  ? !aux_out_q : aux_out_q;

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            ui_cnt_q  <= 5'h00;
            aux_out_q <= 1'b0;
        end
        else
        begin
            ui_cnt_q  <= ui_cnt_d;
            aux_out_q <= aux_out_d;
        end
    end

    // PLL control source: pins or override register
    wire       ovr_en   = ovr_q[`PTC_OVR_EN_BIT];
    wire [1:0] pin_code = {clock_config_pin_1, clock_config_pin_0};
    wire       pll_en_d = ovr_en ? ovr_q[`PTC_OVR_PLLEN_BIT]
                                 : pll_enable_pin;
    wire       se_sel_d = ovr_en ? ovr_q[`PTC_OVR_SE_BIT]
                                 : single_ended_ref_pin;
    wire [1:0] ref_c_d  = ovr_en ? ovr_q[`PTC_OVR_C_MSB:`PTC_OVR_C_LSB]
                                 : pin_code;
    wire [1:0] ref_d_raw = ovr_en ? ovr_q[`PTC_OVR_D_MSB:`PTC_OVR_D_LSB]
                                  : pin_code;
    // D is gated off whenever C is off, so it can never run alone
    wire [1:0] ref_d_d  = (ref_c_d == 2'(ptc_pkg::PTC_REF_OFF))
                          ? 2'(ptc_pkg::PTC_REF_OFF) : ref_d_raw;

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            pll_en_q <= 1'b0;
            se_sel_q <= 1'b0;
            ref_c_q  <= 2'h0;
            ref_d_q  <= 2'h0;
        end
        else
        begin
            pll_en_q <= pll_en_d;
            se_sel_q <= se_sel_d;
            ref_c_q  <= ref_c_d;
            ref_d_q  <= ref_d_d;
        end
    end

    assign reg_rdata             = rdata_q;
    assign oscillator_bias_level = bias_q[`PTC_BIAS_MSB:0];
    // One field fans out to every lane; there is no per-lane copy
    assign lane_preemphasis      = preemph_q[`PTC_PREEMPH_MSB:0];
    assign aux_output_pins       = aux_out_q;
    assign pll_enable            = pll_en_q;
    assign single_ended_ref_sel  = se_sel_q;
    assign ref_out_c_divide      = ref_c_q;
    assign ref_out_d_divide      = ref_d_q;

    property p_readback;
        @(posedge clk) disable iff (!rst_b)
        (wr_ovr ##2 (reg_rd && !reg_wr && reg_addr == `PTC_OFS_OVR))
        |=> reg_rdata == $past(reg_wdata, 3);
    endproperty
    a_readback: assert property (p_readback)
        else $error("Override register did not read back written value");

    property p_preemph_all;
        @(posedge clk) disable iff (!rst_b)
        wr_preemph |=> lane_preemphasis == $past(reg_wdata[3:0]);
    endproperty
    a_preemph_all: assert property (p_preemph_all)
        else $error("Pre-emphasis output does not follow written field");

    property p_aux_off;
        @(posedge clk) disable iff (!rst_b)
        !aux_en |=> !aux_output_pins;
    endproperty
    a_aux_off: assert property (p_aux_off)
        else $error("Aux output active while disabled");

    property p_aux_stamp;
        @(posedge clk) disable iff (!rst_b)
        stamp_mode |=> aux_output_pins == $past(timestamp_input);
    endproperty
    a_aux_stamp: assert property (p_aux_stamp)
        else $error("Aux output is not the resampled timestamp");

    property p_aux_reinit;
        @(posedge clk) disable iff (!rst_b)
        (ser_mode && ser_reinit) |=> !aux_output_pins && ui_cnt_q == 5'h00;
    endproperty
    a_aux_reinit: assert property (p_aux_reinit)
        else $error("Aux clock kept running through serializer restart");

    property p_aux_16ui;
        @(posedge clk) disable iff (!rst_b)
        (ser_mode && !ser_reinit && ser_ui_strobe && ui_cnt_q == 5'h07 &&
         aux_sel == 3'h0) |=> aux_output_pins != $past(aux_output_pins);
    endproperty
    a_aux_16ui: assert property (p_aux_16ui)
        else $error("16 UI clock did not toggle after eight strobes");

    property p_ovr_reset;
        @(posedge clk)
        !rst_b |=> ovr_q == 8'h00 && aux_q == 8'h00 && bias_q == 8'h4f;
    endproperty
    a_ovr_reset: assert property (p_ovr_reset)
        else $error("Register reset value wrong");

    property p_pin_mode;
        @(posedge clk) disable iff (!rst_b)
        !ovr_en |=> pll_enable == $past(pll_enable_pin) &&
                    single_ended_ref_sel == $past(single_ended_ref_pin);
    endproperty
    a_pin_mode: assert property (p_pin_mode)
        else $error("PLL does not follow its pins in pin mode");

    property p_ovr_mode;
        @(posedge clk) disable iff (!rst_b)
        ovr_en |=> pll_enable == $past(ovr_q[0]) &&
                   single_ended_ref_sel == $past(ovr_q[1]) &&
                   ref_out_c_divide == $past(ovr_q[3:2]);
    endproperty
    a_ovr_mode: assert property (p_ovr_mode)
        else $error("PLL does not follow override register");

    property p_d_needs_c;
        @(posedge clk) disable iff (!rst_b)
        ref_out_c_divide == 2'h0 |-> ref_out_d_divide == 2'h0;
    endproperty
    a_d_needs_c: assert property (p_d_needs_c)
        else $error("Reference output D runs while C is off");
endmodule

/* hw/ptc_consts.svh */
// Offsets, field positions, reset values and counts of the config slice
`ifndef PTC_CONSTS_SVH
`define PTC_CONSTS_SVH

`define PTC_OFS_BIAS       8'h3f
`define PTC_OFS_PREEMPH    8'h48
`define PTC_OFS_AUX        8'h57
`define PTC_OFS_OVR        8'h58

`define PTC_RST_BIAS       8'h4f
`define PTC_RST_PREEMPH    8'h00
`define PTC_RST_AUX        8'h00
`define PTC_RST_OVR        8'h00
`define PTC_RD_UNMAPPED    8'h00

`define PTC_BIAS_MSB       6
`define PTC_PREEMPH_MSB    3
`define PTC_AUX_EN_BIT     7
`define PTC_AUX_SEL_MSB    2
`define PTC_OVR_EN_BIT     7
`define PTC_OVR_D_MSB      5
`define PTC_OVR_D_LSB      4
`define PTC_OVR_C_MSB      3
`define PTC_OVR_C_LSB      2
`define PTC_OVR_SE_BIT     1
`define PTC_OVR_PLLEN_BIT  0

// Half periods of the auxiliary clock, counted in UI strobes
`define PTC_HALF_16UI      5'h08
`define PTC_HALF_32UI      5'h10
`define PTC_HALF_64UI      5'h20

`endif

/* hw/ptc_pkg.sv */
// Types shared by the config slice
package ptc_pkg;
    typedef enum logic [2:0] {
        PTC_AUX_UI16  = 3'h0,
        PTC_AUX_UI32  = 3'h1,
        PTC_AUX_UI64  = 3'h2,
        PTC_AUX_STAMP = 3'h3
    } ptc_aux_sel_t;

    typedef enum logic [1:0] {
        PTC_REF_OFF  = 2'h0,
        PTC_REF_DIV1 = 2'h1,
        PTC_REF_DIV2 = 2'h2,
        PTC_REF_DIV4 = 2'h3
    } ptc_ref_div_t;
endpackage

/* verification/ptc_host.sv */
// Configuration host model driving the register strobe port
`timescale 1ns/100ps
module ptc_host (
    input  wire logic       clk,
    output logic            reg_wr,
    output logic            reg_rd,
    output logic      [7:0] reg_addr,
    output logic      [7:0] reg_wdata,
    input  wire logic [7:0] reg_rdata
);
    initial
    begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
    end
    // Released lines flip so a stale value can never pass as fresh
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
        reg_wdata = ~d;
        reg_addr = ~a;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk);
        reg_rd = 1'b0;
        reg_addr = ~a;
        d = reg_rdata;
    endtask
endmodule

/* verification/testbench.sv */
// Self-checking bench of the PLL, pre-emphasis, aux and override registers
`timescale 1ns/100ps
`include "ptc_consts.svh"
module testbench;
    logic       clk, rst_b, reg_wr, reg_rd, ui, reinit, stamp;
    logic       pen, sep, p0, p1, aux, pll_en, se_sel;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, v, r;
    logic [6:0] bias;
    logic [3:0] pe;
    logic [1:0] c_div, d_div;
    integer     seed, mismatches, num_checks, i, m, n;
    ptc_regs u_ptc_regs (.clk(clk), .rst_b(rst_b), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .ser_ui_strobe(ui), .ser_reinit(reinit),
        .timestamp_input(stamp), .pll_enable_pin(pen),
        .single_ended_ref_pin(sep), .clock_config_pin_0(p0),
        .clock_config_pin_1(p1), .oscillator_bias_level(bias),
        .lane_preemphasis(pe), .aux_output_pins(aux), .pll_enable(pll_en),
        .single_ended_ref_sel(se_sel), .ref_out_c_divide(c_div),
        .ref_out_d_divide(d_div));
    ptc_host u_ptc_host (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
    always #25 clk = ~clk;
    task automatic check(input string nm, input logic [7:0] seen,
                         input logic [7:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    function automatic logic [7:0] d_exp(input logic [1:0] c,
                                         input logic [1:0] d);
        return (c == 2'h0) ? 8'h00 : {6'h00, d};
    endfunction
    task automatic rdchk(input string nm, input logic [7:0] a,
                         input logic [7:0] exp);
        u_ptc_host.rd(a, r);
        check(nm, r, exp);
    endtask
    task automatic wait_aux(input logic lvl);
        n = 0;
        while (aux !== lvl && n < 200)
        begin
            @(negedge clk);
            n++;
        end
        if (n >= 200)
        begin
            mismatches++;
            summarize();
        end
    endtask
    // Mode is set while disabled, then enabled, as the host must do
    task automatic aux_half(input logic [2:0] md);
        u_ptc_host.wr(`PTC_OFS_AUX, {5'h00, md});
        u_ptc_host.wr(`PTC_OFS_AUX, {5'h10, md});
        wait_aux(1'b1);
        wait_aux(1'b0);
        check("aux_half", 8'(n), 8'h08 << md);
        wait_aux(1'b1);
        reinit = 1'b1;
        @(negedge clk);
        check("aux_reinit", {7'h0, aux}, 8'h00);
        reinit = 1'b0;
        u_ptc_host.wr(`PTC_OFS_AUX, {5'h00, md});
        // Longer than a 64 UI half period, so a clock that ignored the
        // cleared enable would rise somewhere in this span
        n = 0;
        repeat (40)
        begin
            @(negedge clk);
            n = n | aux;
        end
        check("aux_off", 8'(n), 8'h00);
    endtask
    initial
    begin
        clk = 1'b0;
        seed = 32'h80da;
        mismatches = 0;
        num_checks = 0;
        rst_b = 1'b0;
        {ui, reinit, stamp, pen, sep, p0, p1} = 7'h00;
        repeat (6) @(negedge clk);
        rst_b = 1'b1;
        rdchk("bias_rst", `PTC_OFS_BIAS, `PTC_RST_BIAS);
        rdchk("pe_rst", `PTC_OFS_PREEMPH, 8'h00);
        rdchk("aux_rst", `PTC_OFS_AUX, 8'h00);
        rdchk("ovr_rst", `PTC_OFS_OVR, 8'h00);
        u_ptc_host.wr(`PTC_OFS_BIAS, 8'h4a);
        check("bias_out", {1'b0, bias}, 8'h4a);
        rdchk("bias_rd", `PTC_OFS_BIAS, 8'h4a);
        for (i = 0; i < 8; i++)
        begin
            v = {4'h0, 4'($random(seed))};
            u_ptc_host.wr(`PTC_OFS_PREEMPH, v);
            check("pe_out", {4'h0, pe}, v);
            rdchk("pe_rd", `PTC_OFS_PREEMPH, v);
        end
        u_ptc_host.wr(8'h49, 8'h0f);
        rdchk("unmapped", 8'h49, 8'h00);
        rdchk("pe_kept", `PTC_OFS_PREEMPH, v);
        ui = 1'b1;
        for (m = 0; m < 3; m++)
            aux_half(m[2:0]);
        u_ptc_host.wr(`PTC_OFS_AUX, 8'h03);
        u_ptc_host.wr(`PTC_OFS_AUX, 8'h83);
        for (i = 0; i < 8; i++)
        begin
            stamp = 1'($random(seed));
            @(negedge clk);
            check("aux_stamp", {7'h0, aux}, {7'h0, stamp});
        end
        u_ptc_host.wr(`PTC_OFS_AUX, 8'h03);
        u_ptc_host.wr(`PTC_OFS_AUX, 8'h04);
        u_ptc_host.wr(`PTC_OFS_AUX, 8'h84);
        repeat (40)
        begin
            stamp = ~stamp;
            @(negedge clk);
            check("aux_resv", {7'h0, aux}, 8'h00);
        end
        for (i = 0; i < 12; i++)
        begin
            {p1, p0, sep, pen} = 4'($random(seed));
            repeat (2) @(negedge clk);
            check("pin_en", {7'h0, pll_en}, {7'h0, pen});
            check("pin_se", {7'h0, se_sel}, {7'h0, sep});
            check("pin_c", {6'h0, c_div}, {6'h0, p1, p0});
            check("pin_d", {6'h0, d_div}, d_exp({p1, p0}, {p1, p0}));
        end
        for (i = 0; i < 16; i++)
        begin
            v = {2'b10, 6'($random(seed))};
            if (i < 4)
                v[5:2] = {2'h3, i[1:0]};
            {p1, p0, sep, pen} = ~v[3:0];
            u_ptc_host.wr(`PTC_OFS_OVR, v);
            // Read right after the write so the readback property is armed
            rdchk("ovr_rd", `PTC_OFS_OVR, v);
            check("ovr_en", {7'h0, pll_en}, {7'h0, v[0]});
            check("ovr_se", {7'h0, se_sel}, {7'h0, v[1]});
            check("ovr_c", {6'h0, c_div}, {6'h0, v[3:2]});
            check("ovr_d", {6'h0, d_div}, d_exp(v[3:2], v[5:4]));
        end
        u_ptc_host.wr(`PTC_OFS_OVR, 8'h00);
        @(negedge clk);
        check("pin_back", {7'h0, pll_en}, {7'h0, pen});
        summarize();
    end
endmodule
